/* pkg/pseq_pkg.sv */
/*
  Shared constants and types of the power sequencer strobe configuration block.
  Assumes a 100 MHz core clock; long counts are overridable at the top module.
*/
`default_nettype none
package pseq_pkg;
  // Register offsets on the serial register port
  localparam logic [7:0] GAP_LOW_OFS    = 8'h20;
  localparam logic [7:0] GAP_CTRL_OFS   = 8'h21;
  localparam logic [7:0] BUCK_A_OFS     = 8'h22;
  localparam logic [7:0] BUCK_B_OFS     = 8'h23;
  localparam logic [7:0] BACKUP_OFS     = 8'h24;
  // Values after reset
  localparam logic [7:0] GAP_LOW_RST    = 8'h00;
  localparam logic [7:0] GAP_CTRL_RST   = 8'h00;
  localparam logic [7:0] BUCK_A_RST     = 8'h86;
  localparam logic [7:0] BUCK_B_RST     = 8'h84;
  localparam logic [7:0] BACKUP_RST     = 8'h10;
  // Writable bits
  localparam logic [7:0] GAP_CTRL_MASK  = 8'h81;
  localparam logic [7:0] BACKUP_MASK    = 8'h33;
  // Field positions
  localparam int         MULT_BIT       = 7;
  localparam int         NINTH_BIT      = 0;
  // Strobe codes
  localparam logic [3:0] MAIN_FIRST     = 4'h3;
  localparam logic [3:0] MAIN_LAST      = 4'ha;
  localparam logic [3:0] FIRST_STROBE   = 4'h1;
  localparam logic [3:0] SEALED_FIRST   = 4'h3;
  localparam logic [3:0] LAST_STROBE    = 4'ha;
  localparam logic [1:0] BACKUP_NONE    = 2'h0;
  localparam logic [1:0] BACKUP_OFF     = 2'h3;
  // Timing
  localparam int         CLK_PERIOD_NS  = 10;
  localparam int         GAP_SHORT_MS   = 2;
  localparam int         GAP_LONG_MS    = 5;
  localparam int         SHORT_GAP_CYC  = GAP_SHORT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int         LONG_GAP_CYC   = GAP_LONG_MS * 1000000 / CLK_PERIOD_NS;
  localparam int         PDOWN_SCALE    = 10;
  localparam int         TIMER_W        = 24;
  localparam int         RAIL_CNT       = 6;
  localparam int         MAIN_CNT       = 4;

  typedef logic [TIMER_W-1:0] pseq_count_t;
  typedef enum logic [1:0] {PSEQ_IDLE, PSEQ_STROBE, PSEQ_WAIT} pseq_state_e;
endpackage
`default_nettype wire

/* pkg/pseq_timer_if.sv */
/*
  Carrier between the sequencer and its gap timer.
  Assumes both ends run on the same core clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface pseq_timer_if;
  logic                 start;
  pseq_pkg::pseq_count_t length;
  logic                 done;
  modport ctrl  (output start, output length, input done);
  modport timer (input start, input length, output done);
endinterface
`default_nettype wire

/* logic/pseq_gap_timer.sv */
/*
  Gap timer: counts a loaded number of core clock cycles, then pulses done.
  Assumes start is only raised while the timer is idle.
*/
`timescale 1ns/1ps
`default_nettype none
module pseq_gap_timer (
  input  wire logic   core_clk,
  input  wire logic   rst_n,
  pseq_timer_if.timer tmr
);
  import pseq_pkg::*;

  pseq_count_t remainReg;
  logic        busyReg;
  wire logic   lastCycle = busyReg && (remainReg == '0);

  assign tmr.done = lastCycle;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      remainReg <= '0;
      busyReg   <= 1'b0;
    end else if (tmr.start) begin
      remainReg <= tmr.length - pseq_count_t'(1);
      busyReg   <= 1'b1;
    end else if (busyReg) begin
      remainReg <= remainReg - pseq_count_t'(1);
      busyReg   <= !lastCycle;
    end
  end

  gap_done_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    tmr.start && tmr.length == pseq_count_t'(3) |-> !tmr.done [*3] ##1 tmr.done)
    else $error("Gap timer length wrong");
endmodule
`default_nettype wire

/* logic/pseq_strobe_seq.sv */
/*
  Strobe sequencer with its configuration registers and rail enables.
  Assumes the register port is synchronous to core_clk and that the unlock
  procedure is tracked outside and shown on writeUnlocked.
*/
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Power-down gaps last ten times longer when the multiplier bit is set.
// - Power-up gaps never use the multiplier.
// - Gap nine sits between strobes 9 and 10: 2 ms or 5 ms.
// - Main rail codes 3h to Ah enable at that strobe; others uncontrolled.
// - Backup codes 1h and 2h enable at strobe 1 or 2; others uncontrolled.
// - Buck pair A register resets to 86h.
// - Buck pair B register resets to 84h.
// - Backup rail register resets to 10h.
// - Strobes 1 and 2 run only while the freshness seal is intact.
// - Once the seal is broken, backup rails are never switched off.
// - Gaps one to eight sit between strobes 1 to 9, each 2 ms or 5 ms.
// - Configuration writes take effect only after the unlock procedure.
module pseq_strobe_seq #(
  parameter int SHORT_GAP = pseq_pkg::SHORT_GAP_CYC,
  parameter int LONG_GAP  = pseq_pkg::LONG_GAP_CYC
) (
  input  wire logic                          core_clk,
  input  wire logic                          rst_n,
  input  wire logic                          regWrEn,
  input  wire logic                          regRdEn,
  input  wire logic [7:0]                    regAddr,
  input  wire logic [7:0]                    regWrData,
  output logic      [7:0]                    regRdData,
  input  wire logic                          writeUnlocked,
  input  wire logic                          freshness_seal_flag,
  input  wire logic                          powerUpReq,
  input  wire logic                          powerDownReq,
  output logic      [pseq_pkg::RAIL_CNT-1:0] railEnable,
  output logic      [3:0]                    activeStrobe,
  output logic                               seqBusy
);
  import pseq_pkg::*;

  if (SHORT_GAP < 1 || LONG_GAP < 1 || LONG_GAP * PDOWN_SCALE >= 2 ** TIMER_W) begin : g_chk
    $error("Gap counts out of range for the gap timer");
  end

  pseq_timer_if tmr ();
  pseq_gap_timer u_timer (.core_clk(core_clk), .rst_n(rst_n), .tmr(tmr));

  logic [7:0]          gapLowReg;
  logic [7:0]          gapCtrlReg;
  logic [7:0]          buckAReg;
  logic [7:0]          buckBReg;
  logic [7:0]          backupReg;
  logic [7:0]          rdReg;
  pseq_state_e         stateReg;
  pseq_state_e         stateNext;
  logic [3:0]          strobeReg;
  logic [3:0]          strobeNext;
  logic                downReg;
  logic                downNext;
  logic [RAIL_CNT-1:0] railReg;
  logic [RAIL_CNT-1:0] railNext;

  // Register port decode
  wire logic       wrOk     = regWrEn && writeUnlocked;
  wire logic       wrGapLo  = wrOk && regAddr == GAP_LOW_OFS;
  wire logic       wrGapCt  = wrOk && regAddr == GAP_CTRL_OFS;
  wire logic       wrBuckA  = wrOk && regAddr == BUCK_A_OFS;
  wire logic       wrBuckB  = wrOk && regAddr == BUCK_B_OFS;
  wire logic       wrBackup = wrOk && regAddr == BACKUP_OFS;
  wire logic [7:0] rdMux    = (regAddr == GAP_LOW_OFS)  ? gapLowReg  :
                              (regAddr == GAP_CTRL_OFS) ? gapCtrlReg :
                              (regAddr == BUCK_A_OFS)   ? buckAReg   :
                              (regAddr == BUCK_B_OFS)   ? buckBReg   :
                              (regAddr == BACKUP_OFS)   ? backupReg  : 8'h00;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      gapLowReg  <= GAP_LOW_RST;
      gapCtrlReg <= GAP_CTRL_RST;
      buckAReg   <= BUCK_A_RST;
      buckBReg   <= BUCK_B_RST;
      backupReg  <= BACKUP_RST;
      rdReg      <= 8'h00;
    end else begin
      if (wrGapLo)  gapLowReg  <= regWrData;
      if (wrGapCt)  gapCtrlReg <= regWrData & GAP_CTRL_MASK;
      if (wrBuckA)  buckAReg   <= regWrData;
      if (wrBuckB)  buckBReg   <= regWrData;
      if (wrBackup) backupReg  <= regWrData & BACKUP_MASK;
      if (regRdEn)  rdReg      <= rdMux;
    end
  end
  assign regRdData = rdReg;

  // Strobe fields: buck1, buck2, buck3, buck-boost, then 1.0 V and 1.8 V backup
  wire logic [3:0] mainField [MAIN_CNT];
  assign mainField[0] = buckAReg[3:0];  // buck1_strobe_field
  assign mainField[1] = buckAReg[7:4];  // buck2_strobe_field
  assign mainField[2] = buckBReg[3:0];  // buck3_strobe_field
  assign mainField[3] = buckBReg[7:4];  // buckboost_strobe_field
  wire logic [1:0] backupField [2];
  assign backupField[0] = backupReg[1:0];  // backup_1v0_strobe_field
  assign backupField[1] = backupReg[5:4];  // backup_1v8_strobe_field

  wire logic atStrobe = stateReg == PSEQ_STROBE;
  wire logic [RAIL_CNT-1:0] railHit;
  for (genvar i = 0; i < RAIL_CNT; i++) begin : g_rail
    if (i < MAIN_CNT) begin : g_main
      assign railHit[i] = atStrobe && mainField[i] >= MAIN_FIRST &&
                          mainField[i] <= MAIN_LAST && mainField[i] == strobeReg;
    end else begin : g_backup
      assign railHit[i] = atStrobe && backupField[i-MAIN_CNT] != BACKUP_NONE &&
                          backupField[i-MAIN_CNT] != BACKUP_OFF &&
                          {2'b00, backupField[i-MAIN_CNT]} == strobeReg &&
                          (!downReg || !freshness_seal_flag);
    end
    assign railNext[i] = railHit[i] ? !downReg : railReg[i];
  end

  // Gap selection: gap k follows strobe k on power-up and strobe k+1 on power-down
  wire logic [15:0] gapBits  = {7'h00, gapCtrlReg[NINTH_BIT], gapLowReg};
  wire logic [3:0] gapIdx    = downReg ? strobeReg - 4'h2 : strobeReg - 4'h1;
  wire logic       gapLong   = gapBits[gapIdx];
  wire pseq_count_t gapBase  = gapLong ? pseq_count_t'(LONG_GAP) : pseq_count_t'(SHORT_GAP);
  wire logic       gapScaled = downReg && gapCtrlReg[MULT_BIT];
  wire logic [3:0] firstUp   = freshness_seal_flag ? SEALED_FIRST : FIRST_STROBE;
  wire logic [3:0] endStrobe = downReg ? firstUp : LAST_STROBE;
  wire logic       seqEnd    = strobeReg == endStrobe;

  assign tmr.start  = atStrobe && !seqEnd;
  assign tmr.length = gapScaled ? pseq_count_t'(gapBase * PDOWN_SCALE) : gapBase;

  always_comb begin
    stateNext  = stateReg;
    strobeNext = strobeReg;
    downNext   = downReg;
    case (stateReg)
      PSEQ_IDLE: begin
        if (powerUpReq) begin
          downNext   = 1'b0;
          strobeNext = firstUp;
          stateNext  = PSEQ_STROBE;
        end else if (powerDownReq) begin
          downNext   = 1'b1;
          strobeNext = LAST_STROBE;
          stateNext  = PSEQ_STROBE;
        end
      end
      PSEQ_STROBE: stateNext = seqEnd ? PSEQ_IDLE : PSEQ_WAIT;
      PSEQ_WAIT: begin
        if (tmr.done) begin
          strobeNext = downReg ? strobeReg - 4'h1 : strobeReg + 4'h1;
          stateNext  = PSEQ_STROBE;
        end
      end
      default: stateNext = PSEQ_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stateReg  <= PSEQ_IDLE;
      strobeReg <= 4'h0;
      downReg   <= 1'b0;
      railReg   <= '0;
    end else begin
      stateReg  <= stateNext;
      strobeReg <= strobeNext;
      downReg   <= downNext;
      railReg   <= railNext;
    end
  end

  assign railEnable   = railReg;
  assign activeStrobe = strobeReg;
  assign seqBusy      = stateReg != PSEQ_IDLE;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  pdown_scale_a: assert property (
    tmr.start && downReg && gapCtrlReg[MULT_BIT] |-> tmr.length == gapBase * PDOWN_SCALE)
    else $error("Power-down gap not scaled");
  pup_plain_a: assert property (
    tmr.start && !downReg |-> tmr.length == gapBase)
    else $error("Power-up gap scaled");
  ninth_gap_a: assert property (
    tmr.start && !downReg && strobeReg == 4'h9 |->
    tmr.length == (gapCtrlReg[0] ? LONG_GAP : SHORT_GAP)) else $error("Gap nine wrong");
  gap_select_a: assert property (
    tmr.start && !downReg && strobeReg == 4'h1 |->
    tmr.length == (gapLowReg[0] ? LONG_GAP : SHORT_GAP)) else $error("Gap one wrong");
  main_enable_a: assert property (
    atStrobe && !downReg && buckAReg[3:0] == strobeReg && strobeReg >= MAIN_FIRST
    |=> railEnable[0]) else $error("Buck1 not enabled");
  low_code_a: assert property (
    atStrobe && buckAReg[7:4] < MAIN_FIRST && !railEnable[1] |=> !railEnable[1])
    else $error("Uncontrolled rail switched");
  backup_enable_a: assert property (
    atStrobe && !downReg && backupReg[5:4] == 2'h2 && strobeReg == 4'h2 |=> railEnable[5])
    else $error("Backup rail not enabled");
  backup_first_a: assert property (
    atStrobe && !downReg && backupReg[1:0] == 2'h1 && strobeReg == 4'h1 |=> railEnable[4])
    else $error("Backup 1.0 V rail not enabled");
  reset_vals_a: assert property (
    $past(!rst_n) |-> buckAReg == 8'h86 && buckBReg == 8'h84 && backupReg == 8'h10)
    else $error("Reset values wrong");
  seal_skip_a: assert property (
    freshness_seal_flag && atStrobe |-> strobeReg >= 4'h3)
    else $error("Strobe 1 or 2 ran while sealed");
  seal_first_a: assert property (
    stateReg == PSEQ_IDLE && powerUpReq && freshness_seal_flag |=> atStrobe && strobeReg == 4'h3)
    else $error("Sealed power-up start wrong");
  seal_keep_a: assert property (
    freshness_seal_flag && railEnable[4] |=> railEnable[4])
    else $error("Backup rail disabled after seal");
  seal_hold_a: assert property (
    freshness_seal_flag && railEnable[5] |=> railEnable[5])
    else $error("Backup 1.8 V rail disabled after seal");
  locked_write_a: assert property (
    regWrEn && !writeUnlocked |=> $stable(buckAReg) && $stable(buckBReg) &&
    $stable(gapLowReg) && $stable(gapCtrlReg) && $stable(backupReg))
    else $error("Locked write took effect");
  reserved_zero_a: assert property (
    gapCtrlReg[6:1] == 6'h00 && backupReg[7:6] == 2'h0 && backupReg[3:2] == 2'h0)
    else $error("Reserved bits set");
  unmapped_read_a: assert property (
    regRdEn && regAddr > 8'h24 |=> regRdData == 8'h00)
    else $error("Unmapped read not zero");
  pdown_order_a: assert property (
    stateReg == PSEQ_WAIT && downReg && tmr.done |=>
    atStrobe && strobeReg == $past(strobeReg) - 4'h1) else $error("Power-down order");
  down_start_a: assert property (
    stateReg == PSEQ_IDLE && !powerUpReq && powerDownReq |=> atStrobe && strobeReg == 4'ha)
    else $error("Power-down start wrong");
  down_disable_a: assert property (
    atStrobe && downReg && buckAReg[3:0] == strobeReg && strobeReg >= MAIN_FIRST
    |=> !railEnable[0]) else $error("Buck1 not disabled");
  idle_hold_a: assert property (
    stateReg == PSEQ_IDLE |=> $stable(railEnable))
    else $error("Rail changed while idle");
endmodule
`default_nettype wire

/* testbench/power_sequencer_strobe_config_tb.sv */
/*
  Self-checking bench of the strobe sequencer: registers, strobe order, gaps, seal.
  Assumes pseq_pkg and the design files are compiled first; gaps shortened to 3 and 5.
*/
`timescale 1ns/1ps
`default_nettype none
module power_sequencer_strobe_config_tb;
  import pseq_pkg::*;
  localparam int SG = 3;
  localparam int LG = 5;
  logic       core_clk, rst_n, regWrEn, regRdEn, writeUnlocked;
  logic       freshness_seal_flag, powerUpReq, powerDownReq, seqBusy;
  logic [7:0] regAddr, regWrData, regRdData;
  logic [7:0] cfgA, cfgB, cfgK;
  logic [5:0] railEnable;
  logic [3:0] activeStrobe;
  logic [3:0] vStr [10];
  int         tStr [10];
  int         nStr, base, nErrors, samplesChecked;

  pseq_strobe_seq #(.SHORT_GAP(SG), .LONG_GAP(LG)) i_pseq_strobe_seq (
    .core_clk(core_clk), .rst_n(rst_n), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .writeUnlocked(writeUnlocked), .freshness_seal_flag(freshness_seal_flag),
    .powerUpReq(powerUpReq), .powerDownReq(powerDownReq), .railEnable(railEnable),
    .activeStrobe(activeStrobe), .seqBusy(seqBusy));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic finish_test;
    if (nErrors == 0 && samplesChecked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      nErrors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = d;
    @(negedge core_clk);
    regWrEn = 1'b0;
    @(negedge core_clk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    regRdEn = 1'b1;
    regAddr = a;
    @(negedge core_clk);
    regRdEn = 1'b0;
    @(negedge core_clk);
    chk("regRdData", regRdData, exp);
  endtask

  // Rails that are on once strobes up to s have run
  function automatic logic [5:0] exp_rails(input int s);
    logic [3:0] c [4];
    logic [5:0] r;
    c = '{cfgA[3:0], cfgA[7:4], cfgB[3:0], cfgB[7:4]};
    for (int i = 0; i < 4; i++) r[i] = c[i] >= 3 && c[i] <= 10 && c[i] <= s;
    r[4] = (cfgK[1:0] == 1 || cfgK[1:0] == 2) && cfgK[1:0] <= s;
    r[5] = (cfgK[5:4] == 1 || cfgK[5:4] == 2) && cfgK[5:4] <= s;
    return r;
  endfunction

  // One whole sequence; records each new strobe and its cycle
  task automatic run_seq(input logic up, input logic [5:0] keep);
    int cyc;
    logic [3:0] prev;
    logic busySeen;
    prev = 4'hf;
    nStr = 0;
    busySeen = 1'b0;
    if (up) powerUpReq = 1'b1;
    else powerDownReq = 1'b1;
    @(negedge core_clk);
    powerUpReq = 1'b0;
    powerDownReq = 1'b0;
    chk("seqBusy", 8'(seqBusy), 8'h01);
    for (cyc = 0; cyc < 3000 && !(busySeen && seqBusy === 1'b0); cyc++) begin
      if (seqBusy === 1'b1 && activeStrobe !== prev && nStr < 10) begin
        tStr[nStr] = cyc;
        vStr[nStr] = activeStrobe;
        prev = activeStrobe;
        chk("railEnable", 8'(railEnable), 8'(exp_rails(up ? prev - 1 : prev) | keep));
        nStr++;
      end
      busySeen |= seqBusy === 1'b1;
      @(negedge core_clk);
    end
    if (cyc == 3000) begin
      nErrors++;
      finish_test;
    end else begin
      chk("railEnableEnd", 8'(railEnable), 8'(exp_rails(up ? 10 : 0) | keep));
    end
  endtask

  task automatic t_regs;
    logic [7:0] rv [5];
    rv = '{8'h00, 8'h00, 8'h86, 8'h84, 8'h10};
    for (int i = 0; i < 5; i++) rdchk(8'h20 + 8'(i), rv[i]);
    rdchk(8'h30, 8'h00);
    writeUnlocked = 1'b0;
    wr(8'h22, 8'h2a);
    rdchk(8'h22, 8'h86);
    writeUnlocked = 1'b1;
    wr(8'h21, 8'hff);
    rdchk(8'h21, 8'h81);
    wr(8'h24, 8'hff);
    rdchk(8'h24, 8'h33);
    wr(8'h30, 8'hff);
    rdchk(8'h30, 8'h00);
    cfgA = 8'h2a;
    cfgB = 8'hc3;
    cfgK = 8'h21;
    wr(8'h22, cfgA);
    wr(8'h23, cfgB);
    wr(8'h24, cfgK);
    wr(8'h20, 8'h01);
    wr(8'h21, 8'h81);
    rdchk(8'h23, 8'hc3);
    rdchk(8'h22, 8'h2a);
  endtask

  task automatic t_up;
    run_seq(1'b1, 6'h00);
    chk("strobeCount", 8'(nStr), 8'h0a);
    for (int k = 0; k < 10; k++) chk("strobeUp", 8'(vStr[k]), 8'(k + 1));
    base = tStr[2] - tStr[1];
    chk("gapOne", 8'(tStr[1] - tStr[0] - base), 8'(LG - SG));
    chk("gapNine", 8'(tStr[9] - tStr[8] - base), 8'(LG - SG));
  endtask

  task automatic t_down;
    run_seq(1'b0, 6'h00);
    for (int k = 0; k < 10; k++) chk("strobeDown", 8'(vStr[k]), 8'(10 - k));
    chk("downGapNine", 8'(tStr[1] - tStr[0] - (tStr[2] - tStr[1])), 8'(10 * (LG - SG)));
    chk("downScale", 8'(tStr[2] - tStr[1] - base), 8'(10 * SG - SG));
  endtask

  task automatic t_seal;
    wr(8'h21, 8'h00);
    run_seq(1'b1, 6'h00);
    freshness_seal_flag = 1'b1;
    run_seq(1'b0, 6'h30);
    chk("sealDownCount", 8'(nStr), 8'h08);
    chk("sealDownLast", 8'(vStr[7]), 8'h03);
    run_seq(1'b1, 6'h30);
    chk("sealUpFirst", 8'(vStr[0]), 8'h03);
  endtask

  initial begin
    rst_n = 1'b0;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    writeUnlocked = 1'b0;
    freshness_seal_flag = 1'b0;
    powerUpReq = 1'b0;
    powerDownReq = 1'b0;
    nErrors = 0;
    samplesChecked = 0;
    repeat (8) @(negedge core_clk);
    rst_n = 1'b1;
    t_regs;
    t_up;
    t_down;
    t_seal;
    finish_test;
  end
endmodule
`default_nettype wire
